/* hw/fpfl_top.sv */
// Programmable-flag FIFO: storage, fall-through path, flags, retransmit
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module fpfl_top
#(
	parameter int DEPTH = fpfl_pkg::FPFL_DEPTH_SMALL
)
(
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        ce_i,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [3:0]                  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic                        master_reset_n_i,
	input  wire logic                        partial_reset_n_i,
	input  wire logic                        offset_load_n_i,
	input  wire logic                        fall_through_mode_i,
	input  wire logic                        retransmit_n_i,
	input  wire logic                        wr_en_n_i,
	input  wire logic [fpfl_pkg::FPFL_WIDTH-1:0] wr_data_i,
	input  wire logic                        rd_en_n_i,
	output logic      [fpfl_pkg::FPFL_WIDTH-1:0] data_out_o,
	output logic                             full_flag_n_o,
	output logic                             empty_flag_n_o,
	output logic                             almost_full_flag_n_o,
	output logic                             almost_empty_flag_n_o,
	output logic                             half_full_flag_o
);
	import fpfl_pkg::*;

	// ------------------------------------------------------------
	// Sizes derived from the depth
	// ------------------------------------------------------------
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
	localparam logic [PW-1:0] HALF_P  = PW'(DEPTH / 2);
	localparam logic [15:0]   OFS_MSK = 16'(DEPTH - 1);

	logic [FPFL_WIDTH-1:0] mem [DEPTH];

	logic [PW-1:0]         wr_ptr_r;
	logic [PW-1:0]         rd_ptr_r;
	logic [PW-1:0]         wr_ptr_nxt;
	logic [PW-1:0]         rd_ptr_nxt;
	logic [PW-1:0]         cnt;
	logic [PW-1:0]         cnt_nxt;
	logic [15:0]           full_ofs_r;
	logic [15:0]           empty_ofs_r;
	logic                  fall_through_mode_r;
	logic                  out_valid_r;
	logic                  full_r;
	logic                  empty_n_r;
	logic                  af_s1_r;
	logic                  af_s2_r;
	logic                  ae_s1_r;
	logic                  ae_s2_r;
	logic                  hf_r;
	fpfl_rt_e              rt_state_r;
	logic [3:0]            rt_cnt_r;
	logic                  clr_ptrs;
	logic                  wr_ok;
	logic                  pop;
	logic                  drop;
	logic                  rt_start;
	logic                  flags_live;
	logic                  wb_hit;
	logic [PW-1:0]         af_thr;

	// ------------------------------------------------------------
	// Offset register write merge, shared by both offset registers
	// ------------------------------------------------------------
	function automatic logic [15:0] ofs_merge(input logic [15:0] old_v);
		logic [15:0] v;
		v = old_v;
		if (wb_sel_i[0])
			v[7:0] = wb_dat_i[7:0];
		if (wb_sel_i[1])
			v[15:8] = wb_dat_i[15:8];
		return v & OFS_MSK;
	endfunction : ofs_merge

	// ------------------------------------------------------------
	// Access qualifiers
	// ------------------------------------------------------------
	// Either reset clears the data path; master reset also reloads settings
	assign clr_ptrs = ~master_reset_n_i | ~partial_reset_n_i;
	assign cnt      = wr_ptr_r - rd_ptr_r;
	// Writes are blocked while memory is full
	assign wr_ok    = ~wr_en_n_i & ~full_r & ~clr_ptrs;
	assign rt_start = ~retransmit_n_i & ~clr_ptrs & (rt_state_r == FPFL_RUN);

	// Memory to output register transfer; gated by the memory count, and also by the empty indication in standard mode
	always_comb
	begin
		pop  = 1'b0;
		drop = 1'b0;
		if (!clr_ptrs && rt_state_r != FPFL_RT_SETUP && !rt_start)
		begin
			if (fall_through_mode_r)
			begin
				// Refill an idle output register, or refill on a read
				pop  = (cnt != '0) & (~out_valid_r | ~rd_en_n_i);
				drop = ~rd_en_n_i & out_valid_r & (cnt == '0);
			end
			else
			begin
				pop = ~rd_en_n_i & empty_n_r & (cnt != '0);
			end
		end
	end

	// Next pointers; retransmit rewinds the reader to the first location
	always_comb
	begin
		wr_ptr_nxt = wr_ptr_r + PW'(wr_ok);
		rd_ptr_nxt = rd_ptr_r + PW'(pop);
		if (clr_ptrs)
		begin
			wr_ptr_nxt = '0;
			rd_ptr_nxt = '0;
		end
		else if (rt_start)
			rd_ptr_nxt = '0;
		cnt_nxt = wr_ptr_nxt - rd_ptr_nxt;
	end

	// ------------------------------------------------------------
	// Storage and pointers
	// ------------------------------------------------------------
	// Memory array has no reset; only written words are ever read
	always_ff @(posedge clk_i)
	begin
		if (ce_i && wr_ok)
			mem[wr_ptr_r[AW-1:0]] <= wr_data_i;
	end

	// Pointer registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else if (ce_i)
		begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
		end
	end

	// Output data register; the word here is outside the memory count
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			data_out_o  <= '0;
			out_valid_r <= 1'b0;
		end
		else if (ce_i)
		begin
			if (pop)
				data_out_o <= mem[rd_ptr_r[AW-1:0]];
			if (clr_ptrs || rt_start)
				out_valid_r <= 1'b0;
			else if (pop)
				out_valid_r <= 1'b1;
			else if (drop)
				out_valid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Settings captured at master reset
	// ------------------------------------------------------------
	// Mode and offset defaults are sampled while master reset is low
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fall_through_mode_r      <= 1'b0;
			full_ofs_r  <= FPFL_OFS_DEF_PAR;
			empty_ofs_r <= FPFL_OFS_DEF_PAR;
		end
		else if (ce_i)
		begin
			if (!master_reset_n_i)
			begin
				fall_through_mode_r      <= fall_through_mode_i;
				full_ofs_r  <= offset_load_n_i ? FPFL_OFS_DEF_SER : FPFL_OFS_DEF_PAR;
				empty_ofs_r <= offset_load_n_i ? FPFL_OFS_DEF_SER : FPFL_OFS_DEF_PAR;
			end
			else if (wb_hit && wb_we_i)
			begin
				if (wb_adr_i == FPFL_ADR_FULL_OFS)
					full_ofs_r <= ofs_merge(full_ofs_r);
				if (wb_adr_i == FPFL_ADR_EMPTY_OFS)
					empty_ofs_r <= ofs_merge(empty_ofs_r);
			end
		end
	end

	// ------------------------------------------------------------
	// Retransmit sequencer
	// ------------------------------------------------------------
	// Setup lasts a fixed count, then flags wait for the first access
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rt_state_r <= FPFL_RUN;
			rt_cnt_r   <= '0;
		end
		else if (ce_i)
		begin
			if (clr_ptrs)
			begin
				rt_state_r <= FPFL_RUN;
				rt_cnt_r   <= '0;
			end
			else
			begin
				unique case (rt_state_r)
					FPFL_RUN:
					begin
						if (rt_start)
						begin
							rt_state_r <= FPFL_RT_SETUP;
							rt_cnt_r   <= FPFL_RT_CYCLES - 4'h1;
						end
					end
					FPFL_RT_SETUP:
					begin
						if (rt_cnt_r == 4'h0)
							rt_state_r <= FPFL_RT_HOLD;
						else
							rt_cnt_r <= rt_cnt_r - 4'h1;
					end
					FPFL_RT_HOLD:
					begin
						if (pop)
							rt_state_r <= FPFL_RUN;
					end
				endcase
			end
		end
	end

	// Almost and half-full flags freeze from retransmit until the first location is accessed
	assign flags_live = ((rt_state_r == FPFL_RUN) | pop) & ~rt_start;

	// ------------------------------------------------------------
	// Full and empty indications
	// ------------------------------------------------------------
	// Registered from next count, so a read frees space at the same edge that moves the read pointer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			full_r    <= 1'b0;
			empty_n_r <= 1'b0;
		end
		else if (ce_i)
		begin
			full_r <= (cnt_nxt == DEPTH_P);
			// Empty stays asserted through retransmit setup
			empty_n_r <= (cnt_nxt != '0) & (rt_state_r != FPFL_RT_SETUP) & ~rt_start;
		end
	end

	// Pin polarity follows the selected timing mode
	assign full_flag_n_o  = fall_through_mode_r ? full_r : ~full_r;
	assign empty_flag_n_o = fall_through_mode_r ? ~out_valid_r : empty_n_r;

	// ------------------------------------------------------------
	// Programmable and half-full flags
	// ------------------------------------------------------------
	// Thresholds count memory only, so fall-through needs one write more
	assign af_thr = DEPTH_P - PW'(full_ofs_r[AW-1:0]);

	// Two stages on the almost flags trade one cycle of lag for settling margin; half-full has one
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			af_s1_r <= 1'b1;
			af_s2_r <= 1'b1;
			ae_s1_r <= 1'b0;
			ae_s2_r <= 1'b0;
			hf_r    <= 1'b1;
		end
		else if (ce_i)
		begin
			if (clr_ptrs)
			begin
				af_s1_r <= 1'b1;
				af_s2_r <= 1'b1;
				ae_s1_r <= 1'b0;
				ae_s2_r <= 1'b0;
				hf_r    <= 1'b1;
			end
			else if (flags_live)
			begin
				af_s1_r <= ~(cnt_nxt >= af_thr);
				af_s2_r <= af_s1_r;
				ae_s1_r <= cnt_nxt > PW'(empty_ofs_r[AW-1:0]);
				ae_s2_r <= ae_s1_r;
				// Driven low by writes, high by reads, both seen in one count
				hf_r <= ~(cnt_nxt > HALF_P);
			end
		end
	end

	assign almost_full_flag_n_o  = af_s2_r;
	assign almost_empty_flag_n_o = ae_s2_r;
	assign half_full_flag_o      = hf_r;

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	// One wait state; unmapped reads return zero, writes there are dropped
	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else if (ce_i)
		begin
			wb_ack_o <= wb_hit;
			if (wb_hit && !wb_we_i)
			begin
				wb_dat_o <= '0;
				unique case (wb_adr_i)
					FPFL_ADR_FULL_OFS:
						wb_dat_o[15:0] <= full_ofs_r;
					FPFL_ADR_EMPTY_OFS:
						wb_dat_o[15:0] <= empty_ofs_r;
					FPFL_ADR_STATUS:
					begin
						wb_dat_o[FPFL_ST_CNT_LSB +: PW] <= cnt;
						wb_dat_o[FPFL_ST_FALL_THROUGH_MODE]    <= fall_through_mode_r;
						wb_dat_o[FPFL_ST_OUTVAL]  <= out_valid_r;
						wb_dat_o[FPFL_ST_RT]      <= (rt_state_r != FPFL_RUN);
						wb_dat_o[FPFL_ST_FULL]    <= full_r;
						wb_dat_o[FPFL_ST_EMPTY_N] <= empty_n_r;
						wb_dat_o[FPFL_ST_AF_N]    <= af_s2_r;
						wb_dat_o[FPFL_ST_AE_N]    <= ae_s2_r;
						wb_dat_o[FPFL_ST_HF]      <= hf_r;
					end
					default:
						wb_dat_o <= '0;
				endcase
			end
		end
	end

endmodule : fpfl_top

`default_nettype wire

/* hw/fpfl_pkg.sv */
// Constants shared by the programmable-flag FIFO block
package fpfl_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int FPFL_DEPTH_SMALL = 16384;
	localparam int FPFL_DEPTH_LARGE = 32768;
	localparam int FPFL_WIDTH       = 9;

	// ------------------------------------------------------------
	// Offset defaults chosen at master reset
	// ------------------------------------------------------------
	localparam logic [15:0] FPFL_OFS_DEF_PAR = 16'h007f;
	localparam logic [15:0] FPFL_OFS_DEF_SER = 16'h03ff;

	// ------------------------------------------------------------
	// Retransmit setup length in cycles of the (single) fast clock
	// ------------------------------------------------------------
	localparam logic [3:0] FPFL_RT_CYCLES = 4'he;

	// ------------------------------------------------------------
	// Register map (byte addresses) and status field positions
	// ------------------------------------------------------------
	localparam logic [3:0] FPFL_ADR_FULL_OFS  = 4'h0;
	localparam logic [3:0] FPFL_ADR_EMPTY_OFS = 4'h4;
	localparam logic [3:0] FPFL_ADR_STATUS    = 4'h8;
	localparam int FPFL_ST_CNT_LSB  = 0;
	localparam int FPFL_ST_FALL_THROUGH_MODE     = 16;
	localparam int FPFL_ST_OUTVAL   = 17;
	localparam int FPFL_ST_RT       = 18;
	localparam int FPFL_ST_FULL     = 19;
	localparam int FPFL_ST_EMPTY_N  = 20;
	localparam int FPFL_ST_AF_N     = 21;
	localparam int FPFL_ST_AE_N     = 22;
	localparam int FPFL_ST_HF       = 23;

	// Retransmit sequencer states
	typedef enum logic [1:0]
	{
		FPFL_RUN,
		FPFL_RT_SETUP,
		FPFL_RT_HOLD
	} fpfl_rt_e;

endpackage : fpfl_pkg

/* tb/fpfl_top_properties.sv */
// Port-level assertions for the flag FIFO
`timescale 1ns/1ps
`default_nettype none
module fpfl_top_properties
(
	input wire logic                          clk_i,
	input wire logic                          rst_i,
	input wire logic                          ce_i,
	input wire logic                          wb_cyc_i,
	input wire logic                          wb_stb_i,
	input wire logic                          wb_we_i,
	input wire logic [3:0]                    wb_adr_i,
	input wire logic [31:0]                   wb_dat_o,
	input wire logic                          wb_ack_o,
	input wire logic                          master_reset_n_i,
	input wire logic                          partial_reset_n_i,
	input wire logic                          retransmit_n_i,
	input wire logic                          wr_en_n_i,
	input wire logic                          rd_en_n_i,
	input wire logic [fpfl_pkg::FPFL_WIDTH-1:0] data_out_o,
	input wire logic                          almost_full_flag_n_o,
	input wire logic                          almost_empty_flag_n_o,
	input wire logic                          half_full_flag_o
);
	import fpfl_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [4:0] rt_age_r;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Age since retransmit; a late refill of the output word is legal
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !retransmit_n_i)
			rt_age_r <= 5'h0;
		else if (rt_age_r != 5'h1f)
			rt_age_r <= rt_age_r + 5'h1;
	end
	sequence quiet_s;
		wr_en_n_i && rd_en_n_i && master_reset_n_i && partial_reset_n_i && rt_age_r == 5'h1f;
	endsequence
	sequence take_s;
		ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	chk_ack_answer: assert property (take_s |=> wb_ack_o)
		else $error("no ack after request");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_idle: assert property (!wb_stb_i && !wb_ack_o |=> !wb_ack_o)
		else $error("ack without request");
	chk_unmapped_zero: assert property (take_s ##0 (!wb_we_i && wb_adr_i == 4'hc)
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	chk_hf_fall_write: assert property ($fell(half_full_flag_o) |->
		$past(!wr_en_n_i) || $past(!wr_en_n_i, 2)) else $error("half flag fell without write");
	chk_hf_rise_read: assert property ($rose(half_full_flag_o) |->
		$past(!rd_en_n_i) || $past(!rd_en_n_i, 2) || $past(!partial_reset_n_i)
		|| $past(!master_reset_n_i)) else $error("half flag rose without read");
	chk_af_fall_write: assert property ($fell(almost_full_flag_n_o) |->
		$past(!wr_en_n_i, 2) || $past(!wr_en_n_i, 3)) else $error("almost full without write");
	chk_ae_rise_write: assert property ($rose(almost_empty_flag_n_o) |->
		$past(!wr_en_n_i, 2) || $past(!wr_en_n_i, 3)) else $error("almost empty without write");
	chk_data_hold: assert property (quiet_s [*3] |-> $stable(data_out_o))
		else $error("output word moved while idle");
endmodule : fpfl_top_properties
bind fpfl_top fpfl_top_properties u_fpfl_top_properties (.clk_i(clk_i), .rst_i(rst_i),
	.ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.master_reset_n_i(master_reset_n_i), .partial_reset_n_i(partial_reset_n_i),
	.retransmit_n_i(retransmit_n_i), .wr_en_n_i(wr_en_n_i), .rd_en_n_i(rd_en_n_i),
	.data_out_o(data_out_o), .almost_full_flag_n_o(almost_full_flag_n_o),
	.almost_empty_flag_n_o(almost_empty_flag_n_o), .half_full_flag_o(half_full_flag_o));
`default_nettype wire

/* tb/fpfl_peer.sv */
// Writer model that feeds counted words into the flag FIFO
`timescale 1ns/1ps
`default_nettype none
module fpfl_peer
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        go_i,
	input  wire logic [15:0] cnt_i,
	input  wire logic        full_i,
	output logic             wr_en_n_o,
	output logic [8:0]       wr_data_o,
	output logic             busy_o
);
	logic [15:0] left_nxt;
	logic [8:0]  seq_nxt;
	logic [15:0] left_r;
	logic [8:0]  seq_r;
	logic        acc;
	// A word counts only if the FIFO was not full at the taking edge
	assign acc = !wr_en_n_o && !full_i;
	assign left_nxt = go_i ? cnt_i : left_r - 16'(acc);
	assign seq_nxt = seq_r + 9'(acc);
	assign busy_o = left_r != 16'h0;
	// Idle data is inverted so a stale word never passes for a live one
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			left_r <= 16'h0;
			seq_r <= 9'h0;
			wr_en_n_o <= 1'b1;
		end
		else
		begin
			left_r <= left_nxt;
			seq_r <= seq_nxt;
			wr_en_n_o <= left_nxt == 16'h0;
			wr_data_o <= (left_nxt == 16'h0) ? ~seq_nxt : seq_nxt;
		end
	end
endmodule : fpfl_peer
`default_nettype wire

/* tb/fpfl_top_tb_top.sv */
// Self-checking bench for the flag FIFO
`timescale 1ns/1ps
`default_nettype none
module fpfl_top_tb_top;
	import fpfl_pkg::*;
	localparam int D = FPFL_DEPTH_SMALL;
	logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, mrs_n = 1, prs_n = 1;
	logic        ld_n = 0, ft = 0, rt_n = 1, rd_n = 1, go = 0;
	logic        wen_n, ack, ff_n, ef_n, af_n, ae_n, hf, busy;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = 32'h0, rdat, q;
	logic [15:0] cnt = 16'h0;
	logic [8:0]  wdat, dout, base;
	int          fails = 0, check_count = 0, tick = 0, k, wtot = 0;
	always #50 clk_i = ~clk_i;
	fpfl_top #(.DEPTH(D)) u_fpfl_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
		.wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .master_reset_n_i(mrs_n),
		.partial_reset_n_i(prs_n), .offset_load_n_i(ld_n), .fall_through_mode_i(ft),
		.retransmit_n_i(rt_n), .wr_en_n_i(wen_n), .wr_data_i(wdat), .rd_en_n_i(rd_n),
		.data_out_o(dout), .full_flag_n_o(ff_n), .empty_flag_n_o(ef_n),
		.almost_full_flag_n_o(af_n), .almost_empty_flag_n_o(ae_n), .half_full_flag_o(hf));
	fpfl_peer u_fpfl_peer (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .cnt_i(cnt),
		.full_i(ft ? ff_n : !ff_n), .wr_en_n_o(wen_n), .wr_data_o(wdat), .busy_o(busy));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Classic cycle; a dead slave is caught by the run timeout
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		q = rdat;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task rd_pulse;
		rd_n <= 1'b0;
		@(posedge clk_i);
		rd_n <= 1'b1;
		repeat (3) @(posedge clk_i);
	endtask : rd_pulse
	task push(input int n);
		cnt <= n[15:0];
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge clk_i);
		while (busy)
			@(posedge clk_i);
		repeat (3) @(posedge clk_i);
		wtot += n;
	endtask : push
	task mreset(input logic f, input logic l);
		ft <= f;
		ld_n <= l;
		mrs_n <= 1'b0;
		repeat (2) @(posedge clk_i);
		mrs_n <= 1'b1;
		@(posedge clk_i);
	endtask : mreset
	task close_out;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// Whole run needs about 25k cycles
	always @(posedge clk_i)
	begin
		tick++;
		if (tick == 40000)
		begin
			fails++;
			close_out;
		end
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("flags", 32'h15, {ff_n, ef_n, af_n, ae_n, hf});
		wb(0, FPFL_ADR_FULL_OFS, 0);
		chk("m", 32'h7f, q);
		wb(0, FPFL_ADR_EMPTY_OFS, 0);
		chk("n", 32'h7f, q);
		wb(0, 4'hc, 0);
		chk("unmapped", 0, q);
		rd_pulse;
		chk("q empty", 0, dout);
		$display("test reset done");
		mreset(0, 1);
		wb(0, FPFL_ADR_FULL_OFS, 0);
		chk("m", 32'h3ff, q);
		wb(0, FPFL_ADR_EMPTY_OFS, 0);
		chk("n", 32'h3ff, q);
		wb(1, FPFL_ADR_FULL_OFS, 32'hffff);
		wb(0, FPFL_ADR_FULL_OFS, 0);
		chk("m max", D - 1, q);
		wb(1, FPFL_ADR_EMPTY_OFS, 32'hffff);
		wb(0, FPFL_ADR_EMPTY_OFS, 0);
		chk("n max", D - 1, q);
		wb(1, FPFL_ADR_FULL_OFS, D - 4);
		wb(1, FPFL_ADR_EMPTY_OFS, 2);
		$display("test offsets done");
		base = wtot[8:0];
		push(2);
		chk("ae_n", 0, ae_n);
		push(1);
		chk("ae_n", 1, ae_n);
		chk("af_n", 1, af_n);
		push(1);
		chk("af_n", 0, af_n);
		rd_pulse;
		chk("q", base, dout);
		wb(1, FPFL_ADR_FULL_OFS, 0);
		rt_n <= 1'b0;
		@(posedge clk_i);
		rt_n <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("rt ef_n", 0, ef_n);
		k = 0;
		while (ef_n !== 1'b1 && k < 30)
		begin
			@(posedge clk_i);
			k++;
		end
		chk("rt time", 1, k + 3 <= 17);
		rd_pulse;
		chk("rt q", base, dout);
		$display("test standard done");
		push(8189);
		chk("hf", 1, hf);
		push(1);
		chk("hf", 0, hf);
		rd_pulse;
		chk("hf", 1, hf);
		$display("test half done");
		mreset(1, 0);
		chk("ready", 32'h1, {ff_n, ef_n});
		wb(1, FPFL_ADR_FULL_OFS, D - 4);
		wb(1, FPFL_ADR_EMPTY_OFS, 2);
		base = wtot[8:0];
		push(1);
		chk("ready", 0, ef_n);
		chk("q", base, dout);
		wb(0, FPFL_ADR_STATUS, 0);
		chk("count", 0, q[15:0]);
		rd_pulse;
		chk("ready", 1, ef_n);
		prs_n <= 1'b0;
		repeat (2) @(posedge clk_i);
		prs_n <= 1'b1;
		@(posedge clk_i);
		push(3);
		chk("ae_n", 0, ae_n);
		push(1);
		chk("ae_n", 1, ae_n);
		chk("af_n", 1, af_n);
		push(1);
		chk("af_n", 0, af_n);
		push(8188);
		chk("hf", 1, hf);
		push(1);
		chk("hf", 0, hf);
		push(8191);
		chk("ir full", 1, ff_n);
		rd_pulse;
		chk("ir free", 0, ff_n);
		$display("test fall-through done");
		close_out;
	end
endmodule : fpfl_top_tb_top
`default_nettype wire
